// ---- dv/pg_host.sv ----
// Bus master model driving the guard's register port.
// Assumes the bench calls xfer; signals move on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module pg_host
(
    input  wire logic                         i_mclk,
    output logic                              o_psel,
    output logic                              o_penable,
    output logic                              o_pwrite,
    output logic [pg_pkg::PG_ADDR_W-1:0]      o_paddr,
    output logic [31:0]                       o_pwdata,
    output logic [3:0]                        o_pstrb,
    input  wire logic [31:0]                  i_prdata,
    input  wire logic                         i_pslverr
);
    initial
    begin
        {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata, o_pstrb} = '0;
    end
    // Idle bus shows inverted address and data so stale data never passes for fresh
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic er);
        @(negedge i_mclk);
        {o_psel, o_pwrite, o_paddr, o_pwdata, o_pstrb} = {1'b1, w, a, d, s};
        @(negedge i_mclk);
        o_penable = 1'b1;
        @(posedge i_mclk);
        rd = i_prdata;
        er = i_pslverr;
        @(negedge i_mclk);
        {o_psel, o_penable, o_paddr, o_pwdata} = {2'b00, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the guard: registers, redundant writes, veto.
// Assumes pg_host as bus master and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pg_pkg::*;
    logic        i_mclk, i_rst, psel, pen, pwr, pslverr, pready, tw, t_ok, t_er, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [31:0] exp [3];
    logic [3:0]  pstrb;
    logic [1:0]  tgrp;
    logic [4:0]  tbit;
    logic [32:0] r;
    int          bad_count = 0, check_count = 0, seed, g;
    pg_guard dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_tgt_wr(tw),
        .i_tgt_grp(tgrp), .i_tgt_bit(tbit), .o_tgt_grant(t_ok), .o_tgt_err(t_er));
    pg_host host (.i_mclk(i_mclk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
        .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb), .i_prdata(prdata),
        .i_pslverr(pslverr));
    initial
    begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Redundant bit anywhere rejects the whole write
    function automatic logic [32:0] ex_wr(input logic [31:0] c, input int gg, input logic st,
                                          input logic [31:0] v, input logic [3:0] s);
        logic [31:0] m;
        m = v & PG_WMASK[gg] & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (st ? |(m & c) : |(m & ~c))
            return {1'b1, c};
        return {1'b0, st ? (c | m) : (c & ~m)};
    endfunction
    task automatic wr(input int gg, input logic st, input logic [31:0] v, input logic [3:0] s);
        r = ex_wr(exp[gg], gg, st, v, s);
        host.xfer(1'b1, {2'b00, 2'(gg), st ? PG_OFS_SET : PG_OFS_CLR}, v, s, rd, er);
        chk({31'h0, er}, {31'h0, r[32]});
        chk({31'h0, pready}, 32'h1);
        exp[gg] = r[31:0];
    endtask
    task automatic rdchk(input int gg);
        host.xfer(1'b0, {2'b00, 2'(gg), PG_OFS_CLR}, '0, 4'hf, rd, er);
        chk(rd, exp[gg]);
        host.xfer(1'b0, {2'b00, 2'(gg), PG_OFS_SET}, '0, 4'hf, rd, er);
        chk(rd, exp[gg]);
    endtask
    task automatic veto;
        for (int gg = 0; gg < 4; gg++)
            for (int b = 0; b < 20; b++)
            begin
                @(negedge i_mclk);
                {tw, tgrp, tbit} = {1'b1, 2'(gg), 5'(b)};
                @(posedge i_mclk);
                chk({31'h0, t_er}, {31'h0, gg < 3 ? exp[gg][b] : 1'b0});
                chk({31'h0, t_ok}, {31'h0, gg < 3 ? ~exp[gg][b] : 1'b1});
            end
        @(negedge i_mclk);
        tw = 1'b0;
    endtask
    initial
    begin
        #(20000 * 100);
        bad_count++;
        wrap_up;
    end
    initial
    begin
        seed = 32'h1f54;
        {i_rst, tw, tgrp, tbit} = {1'b1, 8'h00};
        for (g = 0; g < 3; g++)
            exp[g] = PG_RESET[g];
        repeat (6) @(negedge i_mclk);
        i_rst = 1'b0;
        for (g = 0; g < 3; g++)
            rdchk(g);
        host.xfer(1'b0, 12'h300, '0, 4'hf, rd, er);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        host.xfer(1'b1, 12'h008, 32'hffffffff, 4'hf, rd, er);
        chk({31'h0, er}, 32'h1);
        $display("test reset and map done");
        for (g = 0; g < 3; g++)
        begin
            wr(g, 1'b1, 32'hffffffff, 4'hf);
            wr(g, 1'b1, 32'h00000002, 4'hf);
            rdchk(g);
        end
        wr(2, 1'b0, 32'hffffffff, 4'h2);
        wr(0, 1'b0, 32'h1 << PG0_EXTERNAL_INTERRUPT_UNIT, 4'h1);
        veto();
        $display("test protect and veto done");
        // Reset again with state away from its reset values, so reloading is really seen
        @(negedge i_mclk);
        i_rst = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_rst = 1'b0;
        for (g = 0; g < 3; g++)
        begin
            exp[g] = PG_RESET[g];
            rdchk(g);
        end
        $display("test mid-run reset done");
        repeat (300)
        begin
            g = $unsigned($random(seed)) % 3;
            d = $random(seed);
            wr(g, d[31], d[0] ? 32'h1 << d[8:4] : d, d[15:12] | {3'b000, d[1]});
            rdchk(g);
        end
        veto();
        $display("test random done");
        wrap_up;
    end
endmodule
`default_nettype wire

// ---- inc/pg_pkg.sv ----
// Package for the peripheral guard: register map, field masks, reset values.
// Assumes a 32-bit peripheral bus with byte strobes and three guard groups.

package pg_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int unsigned PG_ADDR_W  = 12;
    localparam int unsigned PG_GROUPS  = 3;
    localparam int unsigned PG_GRP_LSB = 8;

    // ************************************************************
    // Register offsets inside one group's space
    // ************************************************************
    localparam logic [7:0] PG_OFS_CLR = 8'h00;
    localparam logic [7:0] PG_OFS_SET = 8'h04;

    // ************************************************************
    // Group 0 field positions
    // ************************************************************
    localparam int unsigned PG0_POWER_MANAGER_UNIT      = 1;
    localparam int unsigned PG0_SYSTEM_CONTROL_UNIT     = 2;
    localparam int unsigned PG0_GENERIC_CLOCK_UNIT      = 3;
    localparam int unsigned PG0_WATCHDOG_UNIT           = 4;
    localparam int unsigned PG0_REAL_TIME_COUNTER       = 5;
    localparam int unsigned PG0_EXTERNAL_INTERRUPT_UNIT = 6;

    // ************************************************************
    // Group 1 and group 2 field positions
    // ************************************************************
    localparam int unsigned PG1_DEBUG_SERVICE_UNIT = 1;
    localparam int unsigned PG2_EVENT_SYSTEM       = 1;
    localparam int unsigned PG2_SERIAL_UNITS_LSB   = 2;
    localparam int unsigned PG2_TIMER_UNITS_LSB    = 8;
    localparam int unsigned PG2_ADC                = 16;
    localparam int unsigned PG2_ANALOG_COMPARATOR  = 17;
    localparam int unsigned PG2_DAC                = 18;
    localparam int unsigned PG2_TOUCH_CONTROLLER   = 19;

    // ************************************************************
    // Writable masks and reset values, one entry per group
    // ************************************************************
    localparam logic [31:0] PG_WMASK [PG_GROUPS] = '{32'h0000007e, 32'h00000002, 32'h000ffffe};
    localparam logic [31:0] PG_RESET [PG_GROUPS] = '{32'h00000000, 32'h00000000, 32'h00800000};

endpackage

// ---- logic/pg_guard.sv ----
// Peripheral write guard: per-group protect clear/set registers and write veto.
// Assumes a single-clock peripheral bus slave port with strobes and error reply.
//
// Function
// RULE1 - Writing zero to a clear-register bit leaves that protection unchanged.
// RULE2 - Writing one to a clear-register bit unprotects that peripheral.
// RULE3 - Group 0 bits 6..1 guard interrupt, counter, watchdog, clock, control, power.
// RULE4 - Group 2 bits 19..1 guard touch, DAC, comparator, ADC, timers, serial, events.
// RULE5 - Clear register at group offset zero; group 2 resets to 0x00800000.
// RULE6 - Writing one to a set bit protects; set and clear read identically.
// RULE7 - Writes to a protected peripheral are dropped and answered with error.
// RULE8 - Protecting a protected or unprotecting an unprotected peripheral gives error.
// RULE9 - Byte, halfword and word accesses work, including each lane alone.
// RULE10 - Unassigned bits ignore writes and read their reset value.

`timescale 1ns/1ps
`default_nettype none

module pg_guard
(
    input  wire logic                         i_mclk,
    input  wire logic                         i_rst,
    input  wire logic                         i_psel,
    input  wire logic                         i_penable,
    input  wire logic                         i_pwrite,
    input  wire logic [pg_pkg::PG_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]                  i_pwdata,
    input  wire logic [3:0]                   i_pstrb,
    output var  logic [31:0]                  o_prdata,
    output logic                              o_pready,
    output logic                              o_pslverr,
    input  wire logic                         i_tgt_wr,
    input  wire logic [1:0]                   i_tgt_grp,
    input  wire logic [4:0]                   i_tgt_bit,
    output logic                              o_tgt_grant,
    output logic                              o_tgt_err
);
    import pg_pkg::*;

    // ************************************************************
    // Address decode
    // ************************************************************
    logic [31:0] prot [PG_GROUPS];
    logic [1:0]  grp;
    logic [7:0]  ofs;
    logic        hit;
    logic        is_clr;
    logic        is_set;
    logic        mapped;
    logic        acc;
    logic        acc_clr;
    logic        acc_set;
    logic [31:0] sel_prot;
    logic [31:0] sel_mask;
    logic [31:0] be;
    logic [31:0] wbits;
    logic        red;
    logic        tgt_prot;

    assign grp    = i_paddr[PG_GRP_LSB+1:PG_GRP_LSB];
    assign ofs    = i_paddr[7:0];
    // Upper address bits must be clear, so no group shows up again higher in the space
    assign hit    = (grp < 2'(PG_GROUPS)) && (i_paddr[PG_ADDR_W-1:PG_GRP_LSB+2] == '0);
    assign is_clr = (ofs == PG_OFS_CLR); // RULE5
    assign is_set = (ofs == PG_OFS_SET);
    assign mapped = hit && (is_clr || is_set);
    assign acc    = i_psel && i_penable;

    assign sel_prot = hit ? prot[grp] : 32'h0;
    assign sel_mask = hit ? PG_WMASK[grp] : 32'h0;
    // Each strobe opens its own byte lane so narrow accesses touch only their bits
    assign be       = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                       {8{i_pstrb[1]}}, {8{i_pstrb[0]}}}; // RULE9
    assign wbits    = i_pwdata & be & sel_mask; // RULE10

    // Any bit already in the requested state makes the whole write redundant
    assign red     = is_clr ? |(wbits & ~sel_prot) : |(wbits & sel_prot); // RULE8
    assign acc_clr = acc && i_pwrite && mapped && is_clr && !red;
    assign acc_set = acc && i_pwrite && mapped && is_set && !red;

    // ************************************************************
    // Bus answer
    // ************************************************************
    // Zero wait states; errors are decided in the access phase
    assign o_pready  = 1'b1;
    assign o_pslverr = acc && (!mapped || (i_pwrite && red)); // RULE8

    // Read data is captured in the setup phase so it stands through access
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_prdata <= 32'h0;
        else if (i_psel && !i_penable && !i_pwrite)
            o_prdata <= mapped ? sel_prot : 32'h0; // RULE6
    end

    // ************************************************************
    // Protection state, one generate entry per group
    // ************************************************************
    // A rejected write changes nothing, so software sees all-or-nothing updates
    for (genvar g = 0; g < PG_GROUPS; g++)
    begin : g_grp
        always_ff @(posedge i_mclk)
        begin
            if (i_rst)
                prot[g] <= PG_RESET[g]; // RULE4
            else if (acc_clr && (grp == 2'(g)))
                prot[g] <= prot[g] & ~wbits; // RULE1 RULE2
            else if (acc_set && (grp == 2'(g)))
                prot[g] <= prot[g] | wbits; // RULE6
        end

        property p_fixed_bits;
            @(posedge i_mclk) disable iff (i_rst)
            (prot[g] & ~PG_WMASK[g]) == (PG_RESET[g] & ~PG_WMASK[g]);
        endproperty
        a_fixed_bits: assert property (p_fixed_bits) // RULE10
            else $error("unassigned guard bit changed");

        // Only an accepted write to this group may move its state
        property p_quiet;
            @(posedge i_mclk) disable iff (i_rst)
            !((acc_clr || acc_set) && (grp == 2'(g))) |=> $stable(prot[g]);
        endproperty
        a_quiet: assert property (p_quiet) // RULE1 RULE8
            else $error("guard state moved without accepted write");
    end

    // ************************************************************
    // Peripheral write veto
    // ************************************************************
    // Group 3 has no guard, so its targets are always granted
    assign tgt_prot    = (i_tgt_grp < 2'(PG_GROUPS)) ? prot[i_tgt_grp][i_tgt_bit] : 1'b0;
    assign o_tgt_grant = i_tgt_wr && !tgt_prot; // RULE7 RULE3 RULE4
    assign o_tgt_err   = i_tgt_wr && tgt_prot; // RULE7

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_clr_zero;
        @(posedge i_mclk) disable iff (i_rst)
        acc_clr |=> ((prot[$past(grp)] ^ $past(sel_prot)) & ~$past(wbits)) == 32'h0;
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("zero write altered guard"); // RULE1

    property p_clr_one;
        @(posedge i_mclk) disable iff (i_rst)
        acc_clr |=> (prot[$past(grp)] & $past(wbits)) == 32'h0;
    endproperty
    a_clr_one: assert property (p_clr_one) else $error("clear did not unprotect"); // RULE2

    property p_grp0_map;
        @(posedge i_mclk) disable iff (i_rst)
        (i_tgt_wr && i_tgt_grp == 2'd0 && i_tgt_bit == 5'(PG0_WATCHDOG_UNIT))
            |-> (o_tgt_err == prot[0][PG0_WATCHDOG_UNIT]);
    endproperty
    a_grp0_map: assert property (p_grp0_map) else $error("group 0 veto mismatch"); // RULE3

    property p_grp2_reset;
        @(posedge i_mclk)
        $past(i_rst) && !i_rst |-> (prot[2][PG2_TOUCH_CONTROLLER:PG2_EVENT_SYSTEM] == 19'h0);
    endproperty
    a_grp2_reset: assert property (p_grp2_reset) else $error("group 2 bits not reset"); // RULE4

    property p_clr_read;
        @(posedge i_mclk) disable iff (i_rst)
        (i_psel && !i_penable && !i_pwrite && grp == 2'd2 && ofs == PG_OFS_CLR)
            |=> (o_prdata == prot[2]) && !o_pslverr;
    endproperty
    a_clr_read: assert property (p_clr_read) else $error("clear read wrong"); // RULE5

    property p_set_one;
        @(posedge i_mclk) disable iff (i_rst)
        acc_set |=> (prot[$past(grp)] & $past(wbits)) == $past(wbits);
    endproperty
    a_set_one: assert property (p_set_one) else $error("set did not protect"); // RULE6

    property p_veto;
        @(posedge i_mclk) disable iff (i_rst)
        (i_tgt_wr && tgt_prot) |-> (!o_tgt_grant && o_tgt_err);
    endproperty
    a_veto: assert property (p_veto) else $error("protected write granted"); // RULE7

    property p_redundant;
        @(posedge i_mclk) disable iff (i_rst)
        (acc && i_pwrite && mapped && red) |-> o_pslverr ##1 (prot[$past(grp)] == $past(sel_prot));
    endproperty
    a_redundant: assert property (p_redundant) else $error("redundant write accepted"); // RULE8

    property p_lanes;
        @(posedge i_mclk) disable iff (i_rst)
        (acc && i_pwrite && mapped && !red)
            |=> ((prot[$past(grp)] ^ $past(sel_prot)) & ~$past(be)) == 32'h0;
    endproperty
    a_lanes: assert property (p_lanes) else $error("write leaked outside strobes"); // RULE9

    property p_set_read;
        @(posedge i_mclk) disable iff (i_rst)
        (i_psel && !i_penable && !i_pwrite && hit && ofs == PG_OFS_SET)
            |=> (o_prdata == prot[$past(grp)]) && !o_pslverr;
    endproperty
    a_set_read: assert property (p_set_read) else $error("set read wrong"); // RULE6

    property p_grp2_map;
        @(posedge i_mclk) disable iff (i_rst)
        (i_tgt_wr && i_tgt_grp == 2'h2 && i_tgt_bit == 5'(PG2_ADC))
            |-> (o_tgt_err == prot[2][PG2_ADC]) && (o_tgt_grant != prot[2][PG2_ADC]);
    endproperty
    a_grp2_map: assert property (p_grp2_map) else $error("group 2 veto mismatch"); // RULE4

    // Relies on the master following every setup cycle with its access cycle
    property p_rd_unmapped;
        @(posedge i_mclk) disable iff (i_rst)
        (i_psel && !i_penable && !i_pwrite && !mapped)
            |=> (o_prdata == 32'h0) && o_pslverr;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) // RULE5
        else $error("unmapped read answered");

    c_clear: cover property (@(posedge i_mclk) disable iff (i_rst) acc_clr && wbits != 32'h0);
    c_set: cover property (@(posedge i_mclk) disable iff (i_rst) acc_set && wbits != 32'h0);
    c_double: cover property (@(posedge i_mclk) disable iff (i_rst) o_pslverr && i_pwrite);
    c_veto: cover property (@(posedge i_mclk) disable iff (i_rst) o_tgt_err);

endmodule

`default_nettype wire
